// ===== iswc_enable_ctrl.sv
// enable transfer, gate drive modes, supply timeout and keep-off control
// Operation
// - three-wire supply loss: gate low after ~300 us
// - drive rate set by power level
// - enable carried modulated, receiver drives gate
// - secondary rail loss: clamp gate low
// - two-wire: enable powers, gate waits power-good
// - two-wire: enable low stops gate, transfer
// - three-wire: transfer whenever primary supply present
// - three-wire, one-shot off: gate follows enable level
// - follow mode: gate tracks enable continuously
// - one-shot, three-wire only: rising edge pulses
// - one-shot pulse high for 2.5 us
// - power level sampled at power-up, held
`timescale 1ns/100ps
module iswc_enable_ctrl #(
    parameter int TIMEOUT_CYCLES = iswc_pkg::TIMEOUT_CYCLES,
    parameter int SLOT_CYCLES = iswc_pkg::BURST_SLOT_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // configuration straps
    input wire logic three_wire_mode,
    input wire logic one_shot_mode,
    input wire logic [2:0] power_level_select,
    // primary side
    input wire logic enable_in,
    input wire logic primary_supply,
    // secondary side status
    input wire logic secondary_high_rail,
    input wire logic secondary_mid_rail,
    input wire logic secondary_power_good,
    // outputs
    output logic gate_drive_out,
    output logic keep_off_clamp,
    output logic xfer_drive,
    output logic carrier_tx
);
    localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
    localparam int SW = $clog2(iswc_pkg::ONESHOT_CYCLES + 1);

    typedef struct packed {
        logic cfg_loaded;
        logic three_wire;
        logic one_shot;
        logic powered_q;
        logic [2:0] level;
        logic phase;
        logic phase_d;
        logic tx_mod;
        logic rx_state;
        logic rx_prev;
        logic pending;
        logic [SW-1:0] shot_cnt;
        logic [SW-1:0] hi_run;
        logic [TW-1:0] timeout_cnt;
        logic timed_out;
        logic gate;
        logic xfer;
        logic clamp;
    } iswc_state_t;

    iswc_state_t r;
    iswc_state_t next_r;

    logic burst_on;
    logic powered;
    logic oneshot;
    logic rails_ok;
    logic gate_allow;

    // burst window runs only while the primary side is powered
    iswc_burst_gen #(
        .SLOT_CYCLES(SLOT_CYCLES)
    ) iswc_burst_gen_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .run(r.powered_q),
        .level(r.level),
        .burst_on(burst_on)
    );

    // primary power source depends on wiring mode
    assign powered = r.cfg_loaded && (r.three_wire ? primary_supply : enable_in);
    assign oneshot = r.three_wire && r.one_shot;
    assign rails_ok = secondary_high_rail && secondary_mid_rail;
    assign gate_allow = secondary_power_good && rails_ok && !r.timed_out;

    // next state of the whole block
    always_comb begin
        next_r = r;
        // straps caught once after reset, then frozen
        if (!r.cfg_loaded) begin
            next_r.cfg_loaded = 1'b1;
            next_r.three_wire = three_wire_mode;
            next_r.one_shot = one_shot_mode;
        end
        next_r.powered_q = powered;
        // level taken only on the power-up edge, held until power cycles
        if (powered && !r.powered_q) begin
            next_r.level = (power_level_select == iswc_pkg::LEVEL_INVALID) ?
                iswc_pkg::LEVEL_FLOOR : power_level_select;
        end
        // transformer drive: burst duty from level, gated by power source
        next_r.xfer = powered && r.powered_q && burst_on;
        // carrier phase flips every cycle while powered; enable rides on it
        next_r.phase = powered ? ~r.phase : 1'b0;
        next_r.phase_d = r.phase;
        next_r.tx_mod = powered && (r.phase ^ enable_in);
        // receiver demodulates against its delayed phase copy
        if (r.powered_q) begin
            next_r.rx_state = r.tx_mod ^ r.phase_d;
        end else if (!r.three_wire) begin
            next_r.rx_state = 1'b0;
        end
        next_r.rx_prev = r.rx_state;
        // three-wire supply loss: receiver holds, timeout pulls gate down
        if (!r.three_wire || primary_supply) begin
            next_r.timeout_cnt = '0;
            next_r.timed_out = 1'b0;
        end else if (!r.timed_out) begin
            if (r.timeout_cnt == TW'(TIMEOUT_CYCLES - 1)) begin
                next_r.timed_out = 1'b1;
            end else begin
                next_r.timeout_cnt = r.timeout_cnt + 1'b1;
            end
        end
        // gate drive, follow or one-shot
        if (!gate_allow) begin
            next_r.gate = 1'b0;
            next_r.shot_cnt = '0;
        end else if (!oneshot) begin
            next_r.gate = r.rx_state;
        end else if (r.gate) begin
            if (r.shot_cnt == '0) begin
                next_r.gate = 1'b0;
            end else begin
                next_r.shot_cnt = r.shot_cnt - 1'b1;
            end
        end else if (r.pending) begin
            next_r.gate = 1'b1;
            next_r.shot_cnt = SW'(iswc_pkg::ONESHOT_CYCLES - 1);
            next_r.pending = 1'b0;
        end
        // a fresh rising edge wins over the clear above, so none is lost
        if (oneshot && r.rx_state && !r.rx_prev) begin
            next_r.pending = 1'b1;
        end
        // run length of high gate, saturating
        if (!r.gate) begin
            next_r.hi_run = '0;
        end else if (r.hi_run != '1) begin
            next_r.hi_run = r.hi_run + 1'b1;
        end
        next_r.clamp = !rails_ok;
    end

    // state register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from state flops
    assign gate_drive_out = r.gate;
    assign keep_off_clamp = r.clamp;
    assign xfer_drive = r.xfer;
    assign carrier_tx = r.tx_mod;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    // named sequences for multi-step behaviour
    sequence seq_supply_expiring;
        r.three_wire && !primary_supply && !r.timed_out && r.timeout_cnt == TW'(TIMEOUT_CYCLES - 1);
    endsequence

    sequence seq_timeout_then_low;
        r.timed_out ##1 !gate_drive_out;
    endsequence

    sequence seq_follow_steady;
        (r.cfg_loaded && !oneshot && gate_allow && r.powered_q) [*2];
    endsequence

    sequence seq_two_wire_off;
        (r.cfg_loaded && !r.three_wire && !enable_in) [*3];
    endsequence

    AST_TIMEOUT_PULLS_LOW: assert property (seq_supply_expiring |=> seq_timeout_then_low)
        else $error("gate not low after supply loss timeout");

    AST_DRIVE_FROM_BURST: assert property (xfer_drive |-> $past(burst_on) && $past(powered))
        else $error("transformer driven outside burst or without power");

    AST_LINK_LATENCY: assert property ($past(r.powered_q) |-> r.rx_state == $past(enable_in, 2))
        else $error("demodulated state differs from enable two cycles back");

    AST_KEEP_OFF: assert property (!rails_ok |=> keep_off_clamp && !gate_drive_out)
        else $error("keep-off not applied on secondary rail loss");

    AST_TWO_WIRE_WAITS_POWER: assert property ((!r.three_wire && $rose(gate_drive_out)) |->
        $past(secondary_power_good) && $past(r.powered_q))
        else $error("two-wire gate rose without power");

    AST_TWO_WIRE_STOP: assert property (seq_two_wire_off |=> !gate_drive_out && !xfer_drive)
        else $error("two-wire enable low did not stop gate and transfer");

    AST_THREE_WIRE_TRANSFER: assert property ((r.cfg_loaded && r.three_wire && primary_supply) [*2] |->
        r.powered_q && r.phase != $past(r.phase))
        else $error("three-wire carrier stopped with supply present");

    AST_FOLLOW_ENABLE: assert property (seq_follow_steady |=> gate_drive_out == $past(enable_in, 3))
        else $error("follow mode gate does not track enable");

    AST_ONESHOT_BOUNDED: assert property ((oneshot && gate_drive_out) |->
        r.hi_run < SW'(iswc_pkg::ONESHOT_CYCLES))
        else $error("one-shot gate held high too long");

    AST_ONESHOT_WIDTH: assert property ((oneshot && $fell(gate_drive_out) && $past(gate_allow)) |->
        r.hi_run == SW'(iswc_pkg::ONESHOT_CYCLES))
        else $error("one-shot pulse width wrong");

    AST_ONESHOT_NEEDS_EDGE: assert property ((oneshot && $rose(gate_drive_out)) |-> $past(r.pending))
        else $error("one-shot pulse without a new rising edge");

    AST_LEVEL_HELD: assert property ((r.powered_q && $past(r.powered_q)) |-> $stable(r.level))
        else $error("power level changed while powered");

    AST_GATE_NEEDS_GOOD: assert property (gate_drive_out |-> $past(secondary_power_good))
        else $error("gate high without secondary power good");

    AST_STRAPS_FIXED: assert property (r.cfg_loaded |=> $stable(r.three_wire) && $stable(r.one_shot))
        else $error("mode straps changed after capture");

endmodule // iswc_enable_ctrl

// ===== iswc_pkg.sv
// shared constants for the isolated switch enable control block
package iswc_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 25;

    // one-shot gate pulse, nominal high time
    localparam int ONESHOT_TIME_NS = 2500;
    localparam int ONESHOT_CYCLES_RAW = ONESHOT_TIME_NS / CLK_PERIOD_NS;
    localparam int ONESHOT_CYCLES = (ONESHOT_CYCLES_RAW < 1) ? 1 : ONESHOT_CYCLES_RAW;

    // primary supply loss timeout, nominal
    localparam int TIMEOUT_TIME_US = 300;
    localparam int TIMEOUT_CYCLES_RAW = (TIMEOUT_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int TIMEOUT_CYCLES = (TIMEOUT_CYCLES_RAW < 1) ? 1 : TIMEOUT_CYCLES_RAW;

    // burst converter: fixed period of slots, on-time is two slots per level
    localparam int BURST_SLOTS = 15;
    localparam int BURST_SLOT_CYCLES = 40;

    // power level setting: 1..7, an out-of-range code falls back to the lowest
    localparam int LEVEL_W = 3;
    localparam logic [2:0] LEVEL_FLOOR = 3'h1;
    localparam logic [2:0] LEVEL_INVALID = 3'h0;

endpackage

// ===== iswc_burst_gen.sv
// burst gate for the barrier transformer drive, duty set by power level
`timescale 1ns/100ps
module iswc_burst_gen #(
    parameter int SLOT_CYCLES = iswc_pkg::BURST_SLOT_CYCLES
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // control
    input wire logic run,
    input wire logic [2:0] level,
    // burst window
    output logic burst_on
);
    localparam int CW = (SLOT_CYCLES > 1) ? $clog2(SLOT_CYCLES) : 1;

    typedef struct packed {
        logic [CW-1:0] cyc;
        logic [3:0] slot;
        logic on;
    } iswc_burst_state_t;

    iswc_burst_state_t r;
    iswc_burst_state_t next_r;

    // slot counter; on-time is level*2 of the fixed slot period
    always_comb begin
        next_r = r;
        if (!run) begin
            next_r = '0;
        end else begin
            next_r.on = (r.slot < {level, 1'b0});
            if (r.cyc == CW'(SLOT_CYCLES - 1)) begin
                next_r.cyc = '0;
                next_r.slot = (r.slot == 4'(iswc_pkg::BURST_SLOTS - 1)) ? 4'h0 : r.slot + 4'h1;
            end else begin
                next_r.cyc = r.cyc + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign burst_on = r.on;

endmodule // iswc_burst_gen

// ===== iswc_host_model.sv
// host controller model driving the enable line of the block
`timescale 1ns/100ps
module iswc_host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // request from the bench
    input wire logic want_en,
    // enable line to the device
    output logic enable_in
);
    int low_cnt;

    // enable is registered, so it changes just after an edge;
    // low_cnt counts edges spent low, so a short low request never locks the line
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable_in <= 1'b0;
            low_cnt <= 0;
        end else if (enable_in) begin
            enable_in <= want_en;
            low_cnt <= 0;
        end else begin
            enable_in <= want_en && (low_cnt >= 2);
            if (low_cnt < 16) begin
                low_cnt <= low_cnt + 1;
            end
        end
    end
endmodule // iswc_host_model

// ===== iswc_enable_ctrl_tb.sv
// self-checking bench for the isolated switch enable control
`timescale 1ns/100ps
module iswc_enable_ctrl_tb;
    localparam int SLOT = 4;
    localparam int TMO = 50;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic three_wire_mode = 1'b1;
    logic one_shot_mode = 1'b0;
    logic [2:0] power_level_select = 3'h7;
    logic want_en = 1'b0;
    logic primary_supply = 1'b1;
    logic secondary_high_rail = 1'b1;
    logic secondary_mid_rail = 1'b1;
    logic secondary_power_good = 1'b1;
    logic enable_in, gate_drive_out, keep_off_clamp, xfer_drive, carrier_tx;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc = 0;
    int c;

    iswc_host_model iswc_host_model_i (.clk_sys(clk_sys), .reset(reset), .want_en(want_en), .enable_in(enable_in));
    iswc_enable_ctrl #(.TIMEOUT_CYCLES(TMO), .SLOT_CYCLES(SLOT)) iswc_enable_ctrl_i (
        .clk_sys(clk_sys), .reset(reset), .three_wire_mode(three_wire_mode), .one_shot_mode(one_shot_mode),
        .power_level_select(power_level_select), .enable_in(enable_in), .primary_supply(primary_supply),
        .secondary_high_rail(secondary_high_rail), .secondary_mid_rail(secondary_mid_rail),
        .secondary_power_good(secondary_power_good), .gate_drive_out(gate_drive_out),
        .keep_off_clamp(keep_off_clamp), .xfer_drive(xfer_drive), .carrier_tx(carrier_tx));

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    task automatic end_sim();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // hang guard, about a thousand cycles are expected
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_sim();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // outputs are sampled at the falling edge, well away from updates
    task automatic wait_gate(input logic v, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_sys);
            if (gate_drive_out === v) break;
        end
        chk({15'h0, gate_drive_out}, {15'h0, v});
    endtask

    // counts high samples of gate (sel=1), transfer drive (sel=0) or carrier (sel=2)
    task automatic count_high(input logic [1:0] sel, input int k, output int cnt);
        cnt = 0;
        repeat (k) begin
            @(negedge clk_sys);
            if ((sel == 2'h2 ? carrier_tx : (sel[0] ? gate_drive_out : xfer_drive)) === 1'b1) cnt++;
        end
    endtask

    // straps only take effect through a reset
    task automatic restart(input logic tw, input logic os, input logic [2:0] lvl);
        @(posedge clk_sys);
        reset <= 1'b1;
        three_wire_mode <= tw;
        one_shot_mode <= os;
        power_level_select <= lvl;
        want_en <= 1'b0;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask

    task automatic set_en(input logic v);
        @(posedge clk_sys);
        want_en <= v;
    endtask

    task automatic sc_follow();
        set_en(1'b1);
        wait_gate(1'b1, 8);
        count_high(2'h1, 20, c);
        chk(c[15:0], 16'h0014);
        // powered carrier flips every cycle whatever enable holds
        count_high(2'h2, 20, c);
        chk(c[15:0], 16'h000A);
        set_en(1'b0);
        wait_gate(1'b0, 8);
    endtask

    task automatic sc_defer();
        @(posedge clk_sys);
        secondary_power_good <= 1'b0;
        set_en(1'b1);
        count_high(1'b1, 12, c);
        chk(c[15:0], 16'h0000);
        @(posedge clk_sys);
        secondary_power_good <= 1'b1;
        wait_gate(1'b1, 6);
        set_en(1'b0);
        wait_gate(1'b0, 8);
    endtask

    task automatic sc_keep_off();
        for (int r = 0; r < 2; r++) begin
            set_en(1'b1);
            wait_gate(1'b1, 8);
            @(posedge clk_sys);
            if (r == 0) begin
                secondary_mid_rail <= 1'b0;
            end else begin
                secondary_high_rail <= 1'b0;
            end
            wait_gate(1'b0, 3);
            chk({15'h0, keep_off_clamp}, 16'h0001);
            // drop enable first so restored rails do not release a stale high
            set_en(1'b0);
            repeat (6) @(posedge clk_sys);
            secondary_mid_rail <= 1'b1;
            secondary_high_rail <= 1'b1;
            repeat (2) @(negedge clk_sys);
            chk({15'h0, keep_off_clamp}, 16'h0000);
            wait_gate(1'b0, 8);
        end
    endtask

    task automatic sc_timeout();
        set_en(1'b1);
        wait_gate(1'b1, 8);
        @(posedge clk_sys);
        primary_supply <= 1'b0;
        // loss seen one edge later, timeout after TMO counts, gate low one edge after that
        count_high(2'h1, 60, c);
        chk(c[15:0], 16'(TMO + 1));
        wait_gate(1'b0, 20);
        set_en(1'b0);
        primary_supply <= 1'b1;
    endtask

    // two full burst periods with enable low; level change is ignored
    task automatic sc_xfer();
        restart(1'b1, 1'b0, 3'h7);
        count_high(1'b0, 30 * SLOT, c);
        chk(c[15:0], 16'(28 * SLOT));
        @(posedge clk_sys);
        power_level_select <= 3'h1;
        count_high(1'b0, 30 * SLOT, c);
        chk(c[15:0], 16'(28 * SLOT));
        restart(1'b1, 1'b0, 3'h0);
        count_high(1'b0, 30 * SLOT, c);
        chk(c[15:0], 16'(4 * SLOT));
    endtask

    task automatic sc_two_wire();
        restart(1'b0, 1'b0, 3'h3);
        set_en(1'b1);
        wait_gate(1'b1, 20);
        count_high(1'b0, 15 * SLOT, c);
        chk(c[15:0], 16'(6 * SLOT));
        set_en(1'b0);
        wait_gate(1'b0, 8);
        repeat (4) @(negedge clk_sys);
        count_high(1'b0, 15 * SLOT, c);
        chk(c[15:0], 16'h0000);
        // unpowered primary sends no carrier at all
        count_high(2'h2, 8, c);
        chk(c[15:0], 16'h0000);
    endtask

    task automatic sc_one_shot();
        restart(1'b1, 1'b1, 3'h7);
        for (int p = 0; p < 2; p++) begin
            set_en(1'b1);
            wait_gate(1'b1, 10);
            count_high(1'b1, 150, c);
            chk(c[15:0], 16'(iswc_pkg::ONESHOT_CYCLES - 1));
            set_en(1'b0);
            // straps moved live must leave the second pulse unchanged
            three_wire_mode <= 1'b0;
            one_shot_mode <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
        sc_follow();
        sc_defer();
        sc_keep_off();
        sc_timeout();
        sc_xfer();
        sc_two_wire();
        sc_one_shot();
        end_sim();
    end
endmodule // iswc_enable_ctrl_tb
